// ===== speed_reference_limit_ramp.sv
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/100ps
// Behaviour
// R1 - speed mode: max on running, min on command
// R2 - torque mode: limits only on restriction command
// R3 - position mode: max on droop command only
// R4 - clamp commands to max/min, defaults given
// R5 - min above start speed runs on start
// R6 - v/f base frequency 60Hz, 20..200Hz
// R7 - base voltage 0..1000V, 8888 95%, 9999 supply
// R8 - up to 17 speeds from four contacts; the code holds 11 presets (3 single-contact plus 8 with extra)
// R9 - multi-speed only external or combined 3/4
// R10 - multi-speed only when remote select is 0
// R11 - presets 0..3600, writable while running
// R12 - jog, pulse, digital, multi, pid, analog priority
// R13 - multi-speed preset overrides analog command
// R14 - three-speed: low beats middle beats high
// R15 - longer time gives slower ramp
// R16 - torque mode ramps restriction value
// R17 - increment select: 0 is 3600s, 1 is 360s
// R18 - decel code 9999 reuses matching accel time
// R19 - times span zero to reference speed
// R20 - second set used while its select on
// R21 - third set wins when both selects on
// R22 - linear ramp per tick, stops at target
// R23 - clamp before ramp
module speed_reference_limit_ramp
  import speed_ramp_pkg::*;
#(
  parameter int COARSE_CYC = UNIT_COARSE_MS * CLK_KHZ,
  parameter int FINE_CYC   = UNIT_FINE_MS * CLK_KHZ
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             start,
  input  wire ms_sel_t          ms_sel,
  input  wire logic             second_set_select,
  input  wire logic             third_set_select,
  input  wire cmd_src_t         src,
  input  wire logic [SPD_W-1:0] droop_speed,
  input  wire logic [9:0]       supply_voltage,
  output logic      [SPD_W-1:0] speed_ref,
  output logic                  ramp_busy,
  output logic      [7:0]       vf_base_freq,
  output logic      [9:0]       vf_base_volt
);

  typedef struct packed {
    ctl_t                       ctl;
    logic [3:0]                 opm;
    logic [1:0]                 rmt;
    logic                       inc;
    logic [SPD_W-1:0]           maxs;
    logic [SPD_W-1:0]           mins;
    logic [SPD_W-1:0]           strt;
    logic [SPD_W-1:0]           refs;
    logic [7:0]                 freq;
    logic [13:0]                volt;
    logic [NTIM-1:0][TIM_W-1:0] tim;
    logic [NPRE-1:0][SPD_W-1:0] pre;
    ramp_st_t                   ramp;
    logic [SPD_W-1:0]           cur;
    logic [ACC_W-1:0]           acc;
    logic [SPD_W-1:0]           spd;
    logic                       busy;
    logic [7:0]                 vff;
    logic [9:0]                 vfv;
    logic                       ack;
    logic [31:0]                dat;
  } state_t;

  state_t s_q;
  state_t s_d;

  ////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [SPD_W-1:0] sat_spd(input logic [31:0] v);
    return (v > 32'(SPD_MAX)) ? SPD_MAX : v[SPD_W-1:0];
  endfunction

  // decel slots alone may hold the reuse code
  function automatic logic [TIM_W-1:0] sat_tim(
    input logic [31:0] v,
    input logic        dec
  );
    logic [TIM_W-1:0] r;
    r = (v > 32'(TIM_HI)) ? TIM_HI : v[TIM_W-1:0];
    if (!dec && r == TIM_SAME) begin
      r = TIM_DEF;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // speed source selection

  logic             ms_on;
  logic             ms_en;
  logic [3:0]       slot;
  logic [SPD_W-1:0] sel_cmd;
  logic [SPD_W-1:0] target;
  logic [SPD_W-1:0] clamped;

  always_comb begin
    ms_on = ms_sel.extra | ms_sel.low | ms_sel.middle | ms_sel.high;
    ms_en = (s_q.opm == OPM_EXT || s_q.opm == OPM_CMB3 ||
             s_q.opm == OPM_CMB4) && (s_q.rmt == RMT_OFF); // R9 R10
    // extra selects the upper block of eight presets
    if (ms_sel.extra) begin
      slot = SLOT_EXT + 4'({ms_sel.low, ms_sel.middle, ms_sel.high}); // R8
    end else if (ms_sel.low) begin
      slot = SLOT_LOW; // R14
    end else if (ms_sel.middle) begin
      slot = SLOT_MID; // R14
    end else begin
      slot = SLOT_HI;
    end
    if (src.jog_v) begin
      sel_cmd = src.jog; // R12
    end else if (src.pulse_v) begin
      sel_cmd = src.pulse; // R12
    end else if (src.dig_v) begin
      sel_cmd = src.dig; // R12
    end else if (ms_en && ms_on) begin
      sel_cmd = s_q.pre[slot]; // R13
    end else if (src.pid_v) begin
      sel_cmd = src.pid; // R12
    end else begin
      sel_cmd = src.analog;
    end
  end

  // limits act before the ramp, so the ramp never overshoots max; min is not applied in position mode or when start is off
  always_comb begin
    clamped = (sel_cmd > s_q.maxs) ? s_q.maxs : sel_cmd; // R4 R23
    if (clamped < s_q.mins) begin
      clamped = s_q.mins; // R4 R5
    end
    if (!start) begin
      target = SPD_ZERO;
    end else if (s_q.ctl == CTL_POSITION) begin
      target = (droop_speed > s_q.maxs) ? s_q.maxs : droop_speed; // R3
    end else begin
      target = clamped; // R1 R2
    end
  end

  ////////////////////////////////////////////////////////////////////
  // ramp time selection

  logic             up;
  logic             dn;
  logic [TIM_W-1:0] acc_t;
  logic [TIM_W-1:0] dec_t;
  logic [TIM_W-1:0] tcode;
  logic [ACC_W-1:0] tcyc;
  logic [ACC_W-1:0] acc_sum;
  logic             step_ok;

  always_comb begin
    up = target > s_q.cur;
    dn = target < s_q.cur;
    if (third_set_select) begin
      acc_t = s_q.tim[TI_ACC3]; // R21
      dec_t = s_q.tim[TI_DEC3];
    end else if (second_set_select) begin
      acc_t = s_q.tim[TI_ACC2]; // R20
      dec_t = s_q.tim[TI_DEC2];
    end else begin
      acc_t = s_q.tim[TI_ACC1];
      dec_t = s_q.tim[TI_DEC1];
    end
    if (dec_t == TIM_SAME) begin
      dec_t = acc_t; // R18
    end
    tcode = up ? acc_t : dec_t;
    // time code counts 0.1s or 0.01s units
    tcyc = ACC_W'(tcode) *
           (s_q.inc ? ACC_W'(FINE_CYC) : ACC_W'(COARSE_CYC)); // R17
    // one r/min per tcyc/refs cycles: refs r/min takes tcyc
    acc_sum = s_q.acc + ACC_W'(s_q.refs); // R19 R15
    step_ok = acc_sum >= tcyc;
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  logic        hit;
  logic [31:0] rdv;
  logic [31:0] wv;
  logic [16:0] pv;

  always_comb begin
    s_d = s_q;
    hit = wb_cyc_i & wb_stb_i & ~s_q.ack;
    rdv = '0;
    case (wb_adr_i)
      ADR_MODE: begin
        rdv[MODE_CTL_LSB +: 2] = s_q.ctl;
        rdv[MODE_OPM_LSB +: 4] = s_q.opm;
        rdv[MODE_RMT_LSB +: 2] = s_q.rmt;
        rdv[MODE_INC_BIT]      = s_q.inc;
      end
      ADR_MAXS: rdv[SPD_W-1:0] = s_q.maxs;
      ADR_MINS: rdv[SPD_W-1:0] = s_q.mins;
      ADR_STRT: rdv[SPD_W-1:0] = s_q.strt;
      ADR_REFS: rdv[SPD_W-1:0] = s_q.refs;
      ADR_FREQ: rdv[7:0] = s_q.freq;
      ADR_VOLT: rdv[13:0] = s_q.volt;
      ADR_STAT: begin
        rdv[SPD_W-1:0] = s_q.cur;
        rdv[STAT_RAMP_LSB +: 3] = s_q.ramp;
      end
      default: rdv = '0;
    endcase
    for (int i = 0; i < NTIM; i++) begin
      if (wb_adr_i == 8'(ADR_TIME + i * ADR_STEP)) begin
        rdv[TIM_W-1:0] = s_q.tim[i];
      end
    end
    for (int i = 0; i < NPRE; i++) begin
      if (wb_adr_i == 8'(ADR_PRE + i * ADR_STEP)) begin
        rdv[SPD_W-1:0] = s_q.pre[i];
      end
    end
    wv = merge(rdv, wb_dat_i, wb_sel_i);

    // bus: one registered answer the cycle after the strobe, ack drops the cycle after
    s_d.ack = hit;
    if (hit) begin
      s_d.dat = rdv;
    end
    if (hit && wb_we_i) begin
      case (wb_adr_i)
        ADR_MODE: begin
          s_d.ctl = ctl_t'(wv[MODE_CTL_LSB +: 2]);
          s_d.opm = wv[MODE_OPM_LSB +: 4];
          s_d.rmt = wv[MODE_RMT_LSB +: 2];
          s_d.inc = wv[MODE_INC_BIT]; // R17
        end
        ADR_MAXS: s_d.maxs = sat_spd(wv); // R4
        ADR_MINS: s_d.mins = sat_spd(wv); // R4
        ADR_STRT: s_d.strt = sat_spd(wv);
        ADR_REFS: begin
          s_d.refs = sat_spd(wv);
          if (s_d.refs == SPD_ZERO) begin
            s_d.refs = SPD_ONE;
          end
        end
        ADR_FREQ: begin
          s_d.freq = (wv > 32'(FREQ_HI)) ? FREQ_HI : wv[7:0]; // R6
          if (s_d.freq < FREQ_LO) begin
            s_d.freq = FREQ_LO; // R6
          end
        end
        ADR_VOLT: begin
          // out-of-range words fall back to the 1000V ceiling
          if (wv == 32'(VOLT_95) || wv == 32'(VOLT_SAME)) begin
            s_d.volt = wv[13:0]; // R7
          end else begin
            s_d.volt = (wv > 32'(VOLT_HI)) ? VOLT_HI : wv[13:0];
          end
        end
        default: s_d.volt = s_q.volt;
      endcase
      for (int i = 0; i < NTIM; i++) begin
        if (wb_adr_i == 8'(ADR_TIME + i * ADR_STEP)) begin
          s_d.tim[i] = sat_tim(wv, (i % 2) == 1);
        end
      end
      // presets take effect at once, even mid-run
      for (int i = 0; i < NPRE; i++) begin
        if (wb_adr_i == 8'(ADR_PRE + i * ADR_STEP)) begin
          s_d.pre[i] = sat_spd(wv); // R11
        end
      end
    end

    // ramp: same law for speed, position and restriction value
    case (s_q.ramp)
      RAMP_HOLD: begin
        s_d.acc = '0;
        if (up) begin
          s_d.ramp = RAMP_UP;
        end else if (dn) begin
          s_d.ramp = RAMP_DOWN;
        end
      end
      RAMP_UP: begin
        if (!up) begin
          s_d.ramp = RAMP_HOLD;
          s_d.acc = '0;
        end else if (tcode == TIM_ZERO) begin
          s_d.cur = target;
        end else if (step_ok) begin
          s_d.cur = s_q.cur + SPD_ONE; // R22 R15 R16
          s_d.acc = acc_sum - tcyc;
        end else begin
          s_d.acc = acc_sum;
        end
      end
      RAMP_DOWN: begin
        if (!dn) begin
          s_d.ramp = RAMP_HOLD;
          s_d.acc = '0;
        end else if (tcode == TIM_ZERO) begin
          s_d.cur = target;
        end else if (step_ok) begin
          s_d.cur = s_q.cur - SPD_ONE; // R22 R15 R16
          s_d.acc = acc_sum - tcyc;
        end else begin
          s_d.acc = acc_sum;
        end
      end
      default: begin
        s_d.ramp = RAMP_HOLD;
        s_d.acc = '0;
      end
    endcase
    s_d.busy = (s_q.ramp != RAMP_HOLD);

    // torque mode passes the restriction value unclamped
    if (s_q.ctl == CTL_TORQUE) begin
      s_d.spd = s_q.cur; // R2 R16
    end else begin
      s_d.spd = (s_q.cur > s_q.maxs) ? s_q.maxs : s_q.cur; // R1 R3
    end

    pv = (17'(supply_voltage) * VOLT_PCT) / PCT_FULL;
    if (s_q.ctl == CTL_VF) begin
      s_d.vff = s_q.freq; // R6
      if (s_q.volt == VOLT_SAME) begin
        s_d.vfv = supply_voltage; // R7
      end else if (s_q.volt == VOLT_95) begin
        s_d.vfv = pv[9:0]; // R7
      end else begin
        s_d.vfv = s_q.volt[9:0];
      end
    end else begin
      s_d.vff = '0;
      s_d.vfv = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_q <= '{ctl: CTL_SPEED, opm: OPM_EXT, rmt: RMT_OFF, inc: 1'b0,
               maxs: MAXS_RST, mins: SPD_ZERO, strt: SPD_ZERO,
               refs: REFS_RST, freq: FREQ_RST, volt: VOLT_SAME,
               tim: {TIM_SAME, TIM_DEF, TIM_SAME, TIM_DEF,
                     TIM_DEF, TIM_DEF},
               pre: '0, ramp: RAMP_HOLD, cur: SPD_ZERO, acc: '0,
               spd: SPD_ZERO, busy: 1'b0, vff: 8'h00, vfv: 10'h000,
               ack: 1'b0, dat: 32'h0000_0000};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o     = s_q.dat;
  assign wb_ack_o     = s_q.ack;
  assign speed_ref    = s_q.spd;
  assign ramp_busy    = s_q.busy;
  assign vf_base_freq = s_q.vff;
  assign vf_base_volt = s_q.vfv;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_run_max_clamp: assert property ( // R1
    ce && s_q.ctl == CTL_SPEED |=> speed_ref <= $past(s_q.maxs))
    else $error("running speed above max limit");

  a_torque_no_clamp: assert property ( // R2
    ce && s_q.ctl == CTL_TORQUE |=> speed_ref == $past(s_q.cur))
    else $error("torque restriction value was clamped");

  a_pos_droop_max: assert property ( // R3
    start && s_q.ctl == CTL_POSITION |->
      target == ((droop_speed > s_q.maxs) ? s_q.maxs : droop_speed))
    else $error("position target not droop clamped");

  a_cmd_clamp: assert property ( // R4
    start && s_q.ctl == CTL_SPEED && s_q.mins <= s_q.maxs |->
      target <= s_q.maxs && target >= s_q.mins)
    else $error("command outside speed limits");

  a_min_on_start: assert property ( // R5
    start && s_q.ctl == CTL_SPEED && s_q.mins > s_q.strt &&
    sel_cmd == SPD_ZERO |-> target == s_q.mins)
    else $error("start without command misses min speed");

  a_vf_freq_out: assert property ( // R6
    ce && s_q.ctl == CTL_VF |=> vf_base_freq == $past(s_q.freq))
    else $error("base frequency not presented");

  a_volt_same: assert property ( // R7
    ce && s_q.ctl == CTL_VF && s_q.volt == VOLT_SAME |=>
      vf_base_volt == $past(supply_voltage))
    else $error("base voltage not supply voltage");

  a_ms_gate: assert property ( // R9
    !ms_en && !src.jog_v && !src.pulse_v && !src.dig_v && !src.pid_v
      |-> sel_cmd == src.analog)
    else $error("multi-speed acted while disabled");

  a_ms_override: assert property ( // R13
    ms_en && ms_on && !src.jog_v && !src.pulse_v && !src.dig_v |->
      sel_cmd == s_q.pre[slot])
    else $error("preset did not override analog");

  a_low_first: assert property ( // R14
    !ms_sel.extra && ms_sel.low |-> slot == SLOT_LOW)
    else $error("low select lost priority");

  a_jog_first: assert property ( // R12
    src.jog_v |-> sel_cmd == src.jog)
    else $error("jog lost priority");

  a_ramp_step: assert property ( // R22
    ce && tcode != TIM_ZERO && tcyc > ACC_W'(s_q.refs) |=>
      s_q.cur == $past(s_q.cur) ||
      s_q.cur == $past(s_q.cur) + SPD_ONE ||
      s_q.cur + SPD_ONE == $past(s_q.cur))
    else $error("ramp moved more than one step");

  a_third_prio: assert property ( // R21
    third_set_select && second_set_select && up |->
      tcode == s_q.tim[TI_ACC3])
    else $error("third time set not chosen");

  a_dec_reuse: assert property ( // R18
    second_set_select && !third_set_select && dn &&
    s_q.tim[TI_DEC2] == TIM_SAME |-> tcode == s_q.tim[TI_ACC2])
    else $error("decel code did not reuse accel time");

endmodule

// ===== speed_ramp_pkg.sv
package speed_ramp_pkg;

  localparam int SPD_W = 12;
  localparam int TIM_W = 16;
  localparam int ACC_W = 42;
  localparam int NPRE  = 11;
  localparam int NTIM  = 6;

  // speeds in r/min
  localparam logic [SPD_W-1:0] SPD_MAX    = 12'he10;
  localparam logic [SPD_W-1:0] SPD_ZERO   = 12'h000;
  localparam logic [SPD_W-1:0] SPD_ONE    = 12'h001;
  localparam logic [SPD_W-1:0] MAXS_RST   = 12'h5dc;
  localparam logic [SPD_W-1:0] REFS_RST   = 12'h5dc;
  localparam logic [7:0]       FREQ_RST   = 8'h3c;
  localparam logic [7:0]       FREQ_LO    = 8'h14;
  localparam logic [7:0]       FREQ_HI    = 8'hc8;
  localparam logic [13:0]      VOLT_HI    = 14'h03e8;
  localparam logic [13:0]      VOLT_95    = 14'h22b8;
  localparam logic [13:0]      VOLT_SAME  = 14'h270f;
  localparam logic [16:0]      VOLT_PCT   = 17'h0005f;
  localparam logic [16:0]      PCT_FULL   = 17'h00064;
  localparam logic [TIM_W-1:0] TIM_HI     = 16'h8ca0;
  localparam logic [TIM_W-1:0] TIM_SAME   = 16'h270f;
  localparam logic [TIM_W-1:0] TIM_DEF    = 16'h0032;
  localparam logic [TIM_W-1:0] TIM_ZERO   = 16'h0000;

  // time units and clock rate
  localparam int UNIT_COARSE_MS = 100;
  localparam int UNIT_FINE_MS   = 10;
  localparam int CLK_KHZ        = 200000;

  // register byte offsets
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_MAXS = 8'h04;
  localparam logic [7:0] ADR_MINS = 8'h08;
  localparam logic [7:0] ADR_STRT = 8'h0c;
  localparam logic [7:0] ADR_REFS = 8'h10;
  localparam logic [7:0] ADR_FREQ = 8'h14;
  localparam logic [7:0] ADR_VOLT = 8'h18;
  localparam logic [7:0] ADR_TIME = 8'h1c;
  localparam logic [7:0] ADR_STAT = 8'h34;
  localparam logic [7:0] ADR_PRE  = 8'h40;
  localparam int         ADR_STEP = 4;

  // mode and status register fields
  localparam int MODE_CTL_LSB  = 0;
  localparam int MODE_OPM_LSB  = 4;
  localparam int MODE_RMT_LSB  = 8;
  localparam int MODE_INC_BIT  = 12;
  localparam int STAT_RAMP_LSB = 16;

  // time slots: accel/decel for sets 1..3
  localparam int TI_ACC1 = 0;
  localparam int TI_DEC1 = 1;
  localparam int TI_ACC2 = 2;
  localparam int TI_DEC2 = 3;
  localparam int TI_ACC3 = 4;
  localparam int TI_DEC3 = 5;

  localparam logic [3:0] OPM_EXT  = 4'h2;
  localparam logic [3:0] OPM_CMB3 = 4'h3;
  localparam logic [3:0] OPM_CMB4 = 4'h4;
  localparam logic [1:0] RMT_OFF  = 2'h0;
  localparam logic [3:0] SLOT_EXT = 4'h3;
  localparam logic [3:0] SLOT_LOW = 4'h2;
  localparam logic [3:0] SLOT_MID = 4'h1;
  localparam logic [3:0] SLOT_HI  = 4'h0;

  typedef enum logic [1:0] {
    CTL_SPEED    = 2'h0,
    CTL_TORQUE   = 2'h1,
    CTL_POSITION = 2'h2,
    CTL_VF       = 2'h3
  } ctl_t;

  typedef enum logic [2:0] {
    RAMP_HOLD = 3'b001,
    RAMP_UP   = 3'b010,
    RAMP_DOWN = 3'b100
  } ramp_st_t;

  typedef struct packed {
    logic extra;
    logic low;
    logic middle;
    logic high;
  } ms_sel_t;

  typedef struct packed {
    logic             jog_v;
    logic [SPD_W-1:0] jog;
    logic             pulse_v;
    logic [SPD_W-1:0] pulse;
    logic             dig_v;
    logic [SPD_W-1:0] dig;
    logic             pid_v;
    logic [SPD_W-1:0] pid;
    logic [SPD_W-1:0] analog;
  } cmd_src_t;

endpackage

// ===== contact_source_model.sv
`timescale 1ns/100ps
module contact_source_model
  import speed_ramp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [2:0]  pick,
  input  wire ms_sel_t     ms_in,
  output cmd_src_t         src,
  output ms_sel_t          ms_sel,
  output logic [SPD_W-1:0] droop_speed,
  output logic [9:0]       supply_voltage
);
  // pick n drops every source ranked above level n
  always_ff @(posedge clk_sys) begin
    src.jog_v      <= pick == 3'h0;
    src.jog        <= 12'h064;
    src.pulse_v    <= pick <= 3'h1;
    src.pulse      <= 12'h0c8;
    src.dig_v      <= pick <= 3'h2;
    src.dig        <= 12'h12c;
    src.pid_v      <= pick <= 3'h3;
    src.pid        <= 12'h01e;
    src.analog     <= (pick == 3'h5) ? 12'h000 : 12'h5dc;
    droop_speed    <= (pick == 3'h7) ? 12'h014 : 12'h4b0;
    supply_voltage <= 10'h0c8;
    ms_sel         <= ms_in;
  end
endmodule

// ===== speed_reference_limit_ramp_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module speed_reference_limit_ramp_tb
  import speed_ramp_pkg::*;
;
  typedef struct packed {
    logic [15:0] mode;
    logic [2:0]  pick;
    logic [3:0]  ms;
    logic [11:0] exp;
  } row_t;
  logic clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, start;
  logic second_set_select, third_set_select, ramp_busy;
  logic [7:0]  wb_adr_i, vf_base_freq;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [2:0]  pick;
  ms_sel_t     ms_in, ms_sel;
  cmd_src_t    src;
  logic [SPD_W-1:0] droop_speed, speed_ref;
  logic [9:0]  supply_voltage, vf_base_volt;
  int err_count, n_compared, cyc_n, t0, t1, t2, t3, tb, d;
  row_t rows [17] = '{
    '{16'h0020, 3'h0, 4'h4, 12'h064}, '{16'h0020, 3'h1, 4'h0, 12'h0c8},
    '{16'h0020, 3'h2, 4'h0, 12'h12c}, '{16'h0020, 3'h3, 4'h1, 12'h2bc},
    '{16'h0020, 3'h3, 4'h3, 12'h320}, '{16'h0020, 3'h3, 4'h7, 12'h384},
    '{16'h0020, 3'h3, 4'h0, 12'h032}, '{16'h0020, 3'h4, 4'h0, 12'h3e8},
    '{16'h0020, 3'h4, 4'h8, 12'h258}, '{16'h0010, 3'h4, 4'h4, 12'h3e8},
    '{16'h0030, 3'h4, 4'h4, 12'h384}, '{16'h0040, 3'h4, 4'h4, 12'h384},
    '{16'h0120, 3'h4, 4'h4, 12'h3e8}, '{16'h0022, 3'h4, 4'h0, 12'h3e8},
    '{16'h0022, 3'h7, 4'h0, 12'h014}, '{16'h0021, 3'h3, 4'h0, 12'h032},
    '{16'h0020, 3'h5, 4'h0, 12'h032}};

  speed_reference_limit_ramp #(.COARSE_CYC(20), .FINE_CYC(2))
    speed_reference_limit_ramp_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .ce(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start(start),
    .ms_sel(ms_sel), .second_set_select(second_set_select),
    .third_set_select(third_set_select), .src(src),
    .droop_speed(droop_speed), .supply_voltage(supply_voltage),
    .speed_ref(speed_ref), .ramp_busy(ramp_busy),
    .vf_base_freq(vf_base_freq), .vf_base_volt(vf_base_volt));
  contact_source_model contact_source_model_inst (.clk_sys(clk_sys),
    .pick(pick), .ms_in(ms_in), .src(src), .ms_sel(ms_sel),
    .droop_speed(droop_speed), .supply_voltage(supply_voltage));

  ////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] dt);
    int k;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= dt;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wait_for(input logic [11:0] v, output int n);
    n = 0;
    while (speed_ref !== v && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  // drop to zero first so every climb starts from rest
  task automatic ramp(input logic s2, input logic s3, output int n);
    int z;
    start <= 1'b0;
    second_set_select <= s2;
    third_set_select <= s3;
    @(posedge clk_sys);
    wait_for(12'h000, z);
    start <= 1'b1;
    @(posedge clk_sys);
    wait_for(12'h064, n);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ceiling well above the longest coarse ramp
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, start} = '0;
    {second_set_select, third_set_select, wb_adr_i, wb_dat_i} = '0;
    pick = 3'h4;
    ms_in = '0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    `CHK(speed_ref, 12'h000)
    wb(0, ADR_MAXS, 0); `CHK(rdat, 32'h5dc)
    wb(0, ADR_FREQ, 0); `CHK(rdat, 32'h03c)
    wb(0, ADR_VOLT, 0); `CHK(rdat, 32'h270f)
    wb(0, ADR_TIME + 12, 0); `CHK(rdat, 32'h270f)
    wb(0, 8'h3c, 0); `CHK(rdat, 32'h0)
    wb(1, ADR_MAXS, 32'h3e8);
    wb(1, ADR_MINS, 32'h032);
    wb(1, ADR_TIME, 32'h0);
    wb(1, ADR_TIME + 4, 32'h0);
    wb(1, ADR_PRE, 32'h2bc);
    wb(1, ADR_PRE + 4, 32'h320);
    wb(1, ADR_PRE + 8, 32'h384);
    wb(1, ADR_PRE + 12, 32'h258);
    start <= 1'b1;
    foreach (rows[i]) begin
      wb(1, ADR_MODE, {16'h0, rows[i].mode});
      pick <= rows[i].pick;
      ms_in <= rows[i].ms;
      repeat (10) @(posedge clk_sys);
      `CHK(speed_ref, rows[i].exp)
    end
    wb(1, ADR_MODE, 32'h0020);
    pick <= 3'h4;
    ms_in <= 4'h4;
    wb(1, ADR_PRE + 8, 32'h190);
    repeat (10) @(posedge clk_sys);
    `CHK(speed_ref, 12'h190)
    wb(1, ADR_MODE, 32'h0023);
    wb(1, ADR_VOLT, 32'h22b8);
    repeat (4) @(posedge clk_sys);
    `CHK(vf_base_volt, 10'h0be)
    wb(1, ADR_VOLT, 32'h5dc);
    wb(1, ADR_FREQ, 32'hfa);
    repeat (4) @(posedge clk_sys);
    `CHK(vf_base_volt, 10'h3e8)
    `CHK(vf_base_freq, 8'hc8)
    // fine units keep each climb short; a reference of 1 makes each r/min step take tcyc cycles
    wb(1, ADR_MODE, 32'h1020);
    wb(1, ADR_REFS, 32'h1);
    wb(1, ADR_MINS, 32'h0);
    wb(1, ADR_TIME, 32'h1);
    wb(1, ADR_TIME + 8, 32'h3);
    wb(1, ADR_TIME + 16, 32'h2);
    pick <= 3'h0;
    ms_in <= 4'h0;
    ramp(0, 0, t1);
    ramp(0, 1, t3);
    ramp(1, 1, tb);
    ramp(1, 0, t2);
    start <= 1'b0;
    @(posedge clk_sys);
    // second-set decel is slow, so the ramp is still busy here
    repeat (5) @(posedge clk_sys);
    `CHK(ramp_busy, 1'b1)
    wait_for(12'h000, d);
    d = d + 5;
    repeat (3) @(posedge clk_sys);
    `CHK(ramp_busy, 1'b0)
    `CHK(t1 >= 195 && t1 <= 215, 1'b1)
    `CHK(t2 > t3 && t3 > t1, 1'b1)
    `CHK(tb == t3, 1'b1)
    `CHK(d >= t2 - 2 && d <= t2 + 2, 1'b1)
    wb(1, ADR_MODE, 32'h0020);
    ramp(0, 0, t0);
    `CHK(t0 > 5 * t1, 1'b1)
    close_out();
  end
endmodule
